// ---- hdl/dcp_top.sv ----
// dual prescaler top: system clock prescaler and watch prescaler hookup
`timescale 1ns/1ps
module dcp_top
    import dcp_pkg::*;
#(
    parameter int SYS_W = SYS_CNT_W
)(
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    input  wire dcp_op_mode_t           op_mode,
    input  wire logic                   watch_clk_in,
    input  wire logic                   subclk_present,
    input  wire logic                   tmr_mode_wr,
    input  wire logic [TMR_MODE_W-1:0]  tmr_mode_wdata,
    output wire logic [SYS_W-1:0]       sys_taps,
    output wire logic [WATCH_TAP_W-1:0] watch_taps
);

    // ************************************************************
    // reset synchroniser
    // ************************************************************
    logic [1:0] rst_sync_q;
    logic       rst_n_int;

    // release reset through two flops
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n_int = rst_sync_q[1];

    // ************************************************************
    // system prescaler run state
    // ************************************************************
    dcp_sys_state_t state_q;
    dcp_sys_state_t state_d;

    // pick input rate from the operating mode
    always_comb begin
        case (op_mode)
            OPM_ACTIVE_HIGH: state_d = SYS_FULL;
            OPM_SLEEP:       state_d = SYS_FULL;
            OPM_ACTIVE_MED:  state_d = SYS_MED;
            default:         state_d = SYS_HALT;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            state_q <= SYS_HALT; // no stray step when released in a halted mode
        end else begin
            state_q <= state_d;
        end
    end

    // ************************************************************
    // system clock prescaler
    // ************************************************************
    logic [MED_DIV_W-1:0] med_div_q;
    logic [MED_DIV_W-1:0] med_div_d;
    logic [SYS_W-1:0]     system_clock_prescaler_q;
    logic [SYS_W-1:0]     system_clock_prescaler_d;

    // next count for the chosen rate
    always_comb begin
        med_div_d                = MED_DIV_RST;
        system_clock_prescaler_d = system_clock_prescaler_q;
        case (state_q)
            SYS_FULL: begin
                system_clock_prescaler_d = system_clock_prescaler_q + SYS_W'(1);
            end
            SYS_MED: begin
                med_div_d = med_div_q + MED_DIV_W'(1);
                if (med_div_q == MED_DIV_W'(MED_DIV - 1)) begin
                    system_clock_prescaler_d = system_clock_prescaler_q + SYS_W'(1);
                end
            end
            default: begin
                system_clock_prescaler_d = SYS_W'(0);
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            med_div_q                <= MED_DIV_RST;
            system_clock_prescaler_q <= SYS_W'(0);
        end else begin
            med_div_q                <= med_div_d;
            system_clock_prescaler_q <= system_clock_prescaler_d;
        end
    end

    // bit k is system clock over 2^(k+1); one shared tap bus
    // count leaves only as taps, no read path
    assign sys_taps = system_clock_prescaler_q;

    // ************************************************************
    // watch clock edge detect and clear decode
    // ************************************************************
    logic        wclk_q;
    logic        wclk_d;
    dcp_watch_if wif ();

    always_comb begin
        wclk_d = watch_clk_in;
    end

    always_ff @(posedge ref_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            wclk_q <= 1'b0;
        end else begin
            wclk_q <= wclk_d;
        end
    end

    // counts in every mode while subclock present
    assign wif.tick  = subclk_present & watch_clk_in & ~wclk_q;
    assign wif.level = watch_clk_in;
    // both clear bits written as ones
    assign wif.clr   = tmr_mode_wr & tmr_mode_wdata[CLR_HI_POS] & tmr_mode_wdata[CLR_LO_POS];

    dcp_watch_clock_prescaler u_watch (
        .clk   (ref_clk),
        .rst_n (rst_n_int),
        .wif   (wif.prov)
    );

    // watch clock over 1 .. 128
    assign watch_taps = wif.taps;

endmodule

// ---- hdl/dcp_pkg.sv ----
// constants, modes and widths shared by the dual prescaler block
package dcp_pkg;

    // ************************************************************
    // counter widths and dividers
    // ************************************************************
    localparam int SYS_CNT_W     = 13;                // system clock prescaler width
    localparam int WATCH_CNT_W   = 5;                 // watch clock prescaler width
    localparam int WATCH_PRE_W   = 2;                 // watch clock divided by four
    localparam int WATCH_TAP_W   = WATCH_CNT_W + WATCH_PRE_W + 1;
    localparam int MED_DIV       = 16;                // medium-speed input divider
    localparam int MED_DIV_W     = $clog2(MED_DIV);

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [SYS_CNT_W-1:0]   SYS_CNT_RST   = 13'h0000;
    localparam logic [WATCH_CNT_W-1:0] WATCH_CNT_RST = 5'h00;
    localparam logic [WATCH_PRE_W-1:0] WATCH_PRE_RST = 2'h0;
    localparam logic [MED_DIV_W-1:0]   MED_DIV_RST   = 4'h0;

    // ************************************************************
    // timekeeping timer mode register fields
    // ************************************************************
    localparam int TMR_MODE_W    = 8;
    localparam int CLR_HI_POS    = 3;                 // watch_prescaler_clear_bit_hi
    localparam int CLR_LO_POS    = 2;                 // watch_prescaler_clear_bit_lo

    // ************************************************************
    // operating modes
    // ************************************************************
    typedef enum logic [2:0] {
        OPM_ACTIVE_HIGH = 3'h0,
        OPM_ACTIVE_MED  = 3'h1,
        OPM_SLEEP       = 3'h2,
        OPM_SUBACTIVE   = 3'h3,
        OPM_SUBSLEEP    = 3'h4,
        OPM_WATCH       = 3'h5,
        OPM_STANDBY     = 3'h6
    } dcp_op_mode_t;

    // system prescaler run state, gray along full -> medium -> halt
    typedef enum logic [1:0] {
        SYS_FULL = 2'h0,
        SYS_MED  = 2'h1,
        SYS_HALT = 2'h3
    } dcp_sys_state_t;

endpackage

// ---- hdl/dcp_watch_if.sv ----
// carrier between the top and the watch clock prescaler
`timescale 1ns/1ps
interface dcp_watch_if;
    import dcp_pkg::*;

    logic                   tick;   // rising edge of the watch clock
    logic                   level;  // raw watch clock level, sampled in the prescaler
    logic                   clr;    // clear request from the mode register
    logic [WATCH_TAP_W-1:0] taps;   // watch clock divided by 1 .. 128

    modport prov (input tick, input level, input clr, output taps);
    modport user (output tick, output level, output clr, input taps);
endinterface

// ---- hdl/dcp_watch_clock_prescaler.sv ----
// watch clock prescaler: divide by four, then a 5-bit counter
`timescale 1ns/1ps
module dcp_watch_clock_prescaler
    import dcp_pkg::*;
(
    input wire logic   clk,
    input wire logic   rst_n,
    dcp_watch_if.prov  wif
);

    logic [WATCH_PRE_W-1:0] pre_q;
    logic [WATCH_PRE_W-1:0] pre_d;
    logic [WATCH_CNT_W-1:0] watch_clock_prescaler_q;
    logic [WATCH_CNT_W-1:0] watch_clock_prescaler_d;
    logic                   lvl_q;
    logic                   lvl_d;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        pre_d                   = pre_q;
        watch_clock_prescaler_d = watch_clock_prescaler_q;
        lvl_d                   = wif.level;
        if (wif.clr) begin
            pre_d                   = WATCH_PRE_RST;
            watch_clock_prescaler_d = WATCH_CNT_RST;
        end else if (wif.tick) begin
            pre_d = pre_q + WATCH_PRE_W'(1);
            if (pre_q == {WATCH_PRE_W{1'b1}}) begin
                watch_clock_prescaler_d = watch_clock_prescaler_q + WATCH_CNT_W'(1);
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    // cleared on reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q                   <= WATCH_PRE_RST;
            watch_clock_prescaler_q <= WATCH_CNT_RST;
            lvl_q                   <= 1'b0;
        end else begin
            pre_q                   <= pre_d;
            watch_clock_prescaler_q <= watch_clock_prescaler_d;
            lvl_q                   <= lvl_d;
        end
    end

    assign wif.taps = {watch_clock_prescaler_q, pre_q, lvl_q};

endmodule

// ---- sim/dcp_top_sva.sv ----
// port-level checker of the dual prescaler top
`timescale 1ns/1ps
module dcp_top_sva
    import dcp_pkg::*;
#(
    parameter int SYS_W = SYS_CNT_W
)(
    input wire logic                   ref_clk,
    input wire logic                   rst_n,
    input wire dcp_op_mode_t           op_mode,
    input wire logic                   watch_clk_in,
    input wire logic                   subclk_present,
    input wire logic                   tmr_mode_wr,
    input wire logic [TMR_MODE_W-1:0]  tmr_mode_wdata,
    input wire logic [SYS_W-1:0]       sys_taps,
    input wire logic [WATCH_TAP_W-1:0] watch_taps
);
    logic [2:0] up_q;
    logic [2:0] up_d;
    logic       ok;
    logic       rise;
    logic       clr;
    // settle counter, history is trusted once it saturates
    always_comb begin
        up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_q <= 3'h0;
        end else begin
            up_q <= up_d;
        end
    end
    // qualified watch edge and clear request
    assign ok   = (up_q == 3'h7);
    assign rise = watch_clk_in && !watch_taps[0] && subclk_present;
    assign clr  = tmr_mode_wr && tmr_mode_wdata[CLR_HI_POS] && tmr_mode_wdata[CLR_LO_POS];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_sys_full_step: assert property (ok && $past(op_mode, 2) inside {OPM_ACTIVE_HIGH, OPM_SLEEP}
        |-> sys_taps == SYS_W'($past(sys_taps) + 1)) else $error("system count not stepping");
    a_sys_halt_zero: assert property (ok && $past(op_mode, 2) > OPM_SLEEP
        |-> sys_taps == '0) else $error("system count not held at zero");
    a_sys_med_step: assert property (ok && $past(op_mode, 2) == OPM_ACTIVE_MED
        |-> $stable(sys_taps) || sys_taps == SYS_W'($past(sys_taps) + 1)) else $error("medium step");
    a_watch_level: assert property (ok |-> watch_taps[0] == $past(watch_clk_in))
        else $error("watch level tap wrong");
    a_watch_step: assert property (ok && $past(rise) && !$past(clr)
        |-> watch_taps[7:1] == 7'($past(watch_taps[7:1]) + 1)) else $error("watch not stepping");
    a_watch_clear: assert property (ok && $past(clr) |-> watch_taps[7:1] == 7'h00)
        else $error("watch clear missed");
    a_watch_gated: assert property (ok && !$past(subclk_present) && !$past(clr)
        |-> $stable(watch_taps[7:1])) else $error("watch counted without subclock");
    a_watch_hold: assert property (ok && !$past(rise) && !$past(clr)
        |-> $stable(watch_taps[7:1])) else $error("watch moved without edge");
    c_sys_wrap: cover property (ok && sys_taps == '0 && $past(sys_taps) == '1);
    c_watch_clr: cover property (ok && clr);
    c_med: cover property (ok && op_mode == OPM_ACTIVE_MED && $changed(sys_taps));
    c_gated: cover property (ok && watch_clk_in && !watch_taps[0] && !subclk_present);
endmodule

// ---- sim/tb.sv ----
// self-checking bench for the dual prescaler top
`timescale 1ns/1ps
module tb;
    import dcp_pkg::*;
    logic                   ref_clk        = 1'b0;
    logic                   rst_n          = 1'b0;
    dcp_op_mode_t           op_mode        = OPM_STANDBY;
    logic                   watch_clk_in   = 1'b0;
    logic                   subclk_present = 1'b1;
    logic                   tmr_mode_wr    = 1'b0;
    logic [TMR_MODE_W-1:0]  tmr_mode_wdata = 8'h00;
    logic [SYS_CNT_W-1:0]   sys_taps;
    logic [WATCH_TAP_W-1:0] watch_taps;
    int                     bad_count      = 0;
    int                     checks_done    = 0;
    int                     cyc_n          = 0;
    logic [6:0]             wv             = 7'h00; // expected watch count with pre-divider
    dcp_top dcp_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .op_mode(op_mode),
        .watch_clk_in(watch_clk_in), .subclk_present(subclk_present), .tmr_mode_wr(tmr_mode_wr),
        .tmr_mode_wdata(tmr_mode_wdata), .sys_taps(sys_taps), .watch_taps(watch_taps));
    // 200 MHz clock
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    // hang guard
    always @(posedge ref_clk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            bad_count++;
            results();
        end
    end
    task automatic cy(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // square wave stimulus
    // n watch clock rises, each with low samples between
    task automatic rise(input int n);
        repeat (n) begin
            cy(1);
            watch_clk_in <= 1'b1;
            cy(2);
            watch_clk_in <= 1'b0;
            cy(1);
        end
        if (subclk_present) wv = wv + 7'(n);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic t_reset();
        cy(3);
        @(negedge ref_clk);
        chk(16'(sys_taps), 16'h0000);
        chk(16'(watch_taps), 16'h0000);
        cy(3);
        rst_n <= 1'b1;
        cy(10);
        @(negedge ref_clk);
        chk(16'(sys_taps), 16'h0000);
        $display("test reset done");
    endtask
    task automatic t_sys_full();
        cy(1);
        op_mode <= OPM_ACTIVE_HIGH;
        cy(100);
        @(negedge ref_clk);
        chk(16'(sys_taps), 16'h0063);
        cy(1);
        op_mode <= OPM_SLEEP;
        cy(8191);
        @(negedge ref_clk);
        chk(16'(sys_taps), 16'h0063);
        $display("test sys_full done");
    endtask
    task automatic t_sys_halt();
        dcp_op_mode_t lp [4] = '{OPM_SUBACTIVE, OPM_SUBSLEEP, OPM_WATCH, OPM_STANDBY};
        foreach (lp[i]) begin
            cy(1);
            op_mode <= OPM_ACTIVE_HIGH;
            cy(5);
            op_mode <= lp[i];
            cy(3);
            @(negedge ref_clk);
            chk(16'(sys_taps), 16'h0000);
        end
        $display("test sys_halt done");
    endtask
    task automatic t_sys_med();
        cy(1);
        op_mode <= OPM_ACTIVE_MED;
        cy(8);
        @(negedge ref_clk);
        chk(16'(sys_taps), 16'h0000);
        cy(160);
        @(negedge ref_clk);
        chk(16'(sys_taps), 16'h000A);
        cy(1);
        op_mode <= OPM_STANDBY;
        $display("test sys_med done");
    endtask
    task automatic t_watch();
        logic [7:0] wd [3] = '{8'hF7, 8'hFB, 8'h0C};
        rise(5);
        cy(3);
        @(negedge ref_clk);
        chk(16'(watch_taps[7:1]), 16'(wv));
        chk(16'(watch_taps[0]), 16'h0000);
        rise(128);
        cy(3);
        @(negedge ref_clk);
        chk(16'(watch_taps[7:1]), 16'(wv));
        cy(1);
        subclk_present <= 1'b0;
        rise(3);
        cy(3);
        @(negedge ref_clk);
        chk(16'(watch_taps[7:1]), 16'(wv));
        cy(1);
        subclk_present <= 1'b1;
        foreach (wd[i]) begin
            cy(1);
            tmr_mode_wr <= 1'b1;
            tmr_mode_wdata <= wd[i];
            cy(1);
            tmr_mode_wr <= 1'b0;
            cy(2);
            @(negedge ref_clk);
            if (wd[i] == 8'h0C) wv = 7'h00;
            chk(16'(watch_taps[7:1]), 16'(wv));
        end
        $display("test watch done");
    endtask
    // main sequence
    initial begin
        t_reset();
        t_sys_full();
        t_sys_halt();
        t_sys_med();
        t_watch();
        results();
    end
endmodule
bind dcp_top dcp_top_sva #(.SYS_W(SYS_W)) dcp_top_sva_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .op_mode(op_mode), .watch_clk_in(watch_clk_in), .subclk_present(subclk_present),
    .tmr_mode_wr(tmr_mode_wr), .tmr_mode_wdata(tmr_mode_wdata), .sys_taps(sys_taps),
    .watch_taps(watch_taps));
